// ==== rtl/usb_ls_pkg.sv ====
// Shared constants and types for the low-speed USB bus-state logic
package usb_ls_pkg;

   // -------------------------------------------------------------------
   // Clock and bit timing
   // -------------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int SAMPLE_HZ = 6_000_000;
   localparam int BIT_RATE_HZ = 1_500_000;
   localparam int SAMPLES_PER_BIT = SAMPLE_HZ / BIT_RATE_HZ;
   localparam int EOP_SE0_BITS = 2;
   localparam int EOP_J_BITS = 1;
   localparam int RESET_MIN_BITS = 4;
   localparam longint EOP_REJECT_NS = 330;
   localparam longint IDLE_SUSPEND_US = 3000;
   localparam longint WAKE_IDLE_US = 5000;

   // Widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W = 6;
   localparam int IDLE_W = 16;
   localparam int DEV_ADDR_W = 7;

   // Derived counts, in line samples
   localparam logic [CNT_W-1:0] EOP_SE0_SAMPLES = CNT_W'(EOP_SE0_BITS * SAMPLES_PER_BIT);
   localparam logic [CNT_W-1:0] EOP_J_SAMPLES = CNT_W'(EOP_J_BITS * SAMPLES_PER_BIT);
   localparam logic [CNT_W-1:0] RESET_SAMPLES = CNT_W'(RESET_MIN_BITS * SAMPLES_PER_BIT);
   // n samples span only n-1 periods, so one more than the rounded-up width
   localparam logic [CNT_W-1:0] EOP_MIN_SAMPLES =
      CNT_W'((EOP_REJECT_NS * SAMPLE_HZ + 64'd999_999_999) / 64'd1_000_000_000 + 64'd1);
   localparam int IDLE_SUSPEND_SAMPLES = int'(IDLE_SUSPEND_US * SAMPLE_HZ / 1_000_000);
   localparam int WAKE_IDLE_SAMPLES = int'(WAKE_IDLE_US * SAMPLE_HZ / 1_000_000);

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_USB_INTERRUPT_REG_ZERO = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_USB_CONTROL_REG_ONE = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_BUS_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_DEVICE_ADDRESS = 4'h3;
   // Interrupt register zero
   localparam int BIT_PACKET_END_SEEN = 0;
   localparam int BIT_BUS_RESET = 1;
   localparam int BIT_RESUME_SEEN = 2;
   localparam int BIT_SUSPEND_REQUEST = 3;
   // Control register one
   localparam int BIT_FORCE_WAKEUP = 0;
   // Bus status
   localparam int BIT_SUSPENDED = 0;
   localparam int BIT_IDLE_3MS = 1;
   localparam int BIT_WAKE_DRIVING = 2;
   localparam int BIT_LINE_J = 3;
   localparam int BIT_LINE_SE0 = 4;
   localparam int BIT_RESET_ACTIVE = 5;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   // Line code is {dp, dm}; low speed idles with dm high
   typedef enum logic [1:0] {
      LINE_SE0 = 2'b00,
      LINE_J = 2'b01,
      LINE_K = 2'b10,
      LINE_SE1 = 2'b11
   } line_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SE0 = 2'b10,
      TX_J = 2'b11
   } tx_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic tick;
      line_t line;
   } sample_t;

endpackage

// ==== rtl/usb_line_sampler.sv ====
// Sample-rate enable and line sampler for the D+/D- receivers
`timescale 1ns/1ps
`default_nettype none

module usb_line_sampler #(
   parameter int CLK_HZ = usb_ls_pkg::CLK_HZ,
   parameter int SAMPLE_HZ = usb_ls_pkg::SAMPLE_HZ
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Line receivers
   input wire logic dp_i,
   input wire logic dm_i,
   // Sample stream
   output usb_ls_pkg::sample_t smp_o
);
   import usb_ls_pkg::*;

   typedef struct packed {
      logic [31:0] acc;
      sample_t smp;
   } smp_state_t;

   smp_state_t q, d;
   logic [31:0] sum;

   generate
      if (SAMPLE_HZ <= 0 || SAMPLE_HZ >= CLK_HZ) begin : g_bad_rate
         $error("Sample rate must be positive and below the clock rate");
      end
   endgenerate

   // -------------------------------------------------------------------
   // Fractional divider: 100 MHz does not divide to 6 MHz evenly
   // -------------------------------------------------------------------
   always_comb begin
      d = q;
      sum = q.acc + 32'(SAMPLE_HZ);
      d.smp.tick = 1'b0;
      if (sum >= 32'(CLK_HZ)) begin
         d.acc = sum - 32'(CLK_HZ);
         d.smp.tick = 1'b1;
         d.smp.line = line_t'({dp_i, dm_i});
      end else begin
         d.acc = sum;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign smp_o = q.smp;

endmodule

`default_nettype wire

// ==== rtl/usb_ls_bus_state_control.sv ====
// Low-speed USB bus-state logic: EOP, bus reset, suspend and resume
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - End of packet is two bit times of SE0, then one bit time of J.
// - After that J bit, both line drivers go high impedance.
// - Packet ends exactly at the SE0 to J change.
// - SE0 of 2.5 us or more is reset; recognised by 5.5 us.
// - SE0 lasting 4 to 8 bit times is a valid bus reset.
// - Bus reset holds device in reset; reset flag set on release.
// - After reset device is unaddressed; new address accepted at once.
// - Bus reset wakes the device from suspend well within 10 ms.
// - Suspend entered by the suspend request bit; firmware watches EOP flag.
// - Suspend ends on bus activity, bus reset or forced wake-up.
// - While force wake-up bit is set, drive K upstream.
// - Wake-up K starts only after 5 ms of idle bus.
// - Firmware holds force wake-up 10 to 15 ms; hardware does not time it.
// - Clearing force wake-up releases the lines to high impedance.
// - Transmitted EOP SE0 lasts 1.25 to 1.50 us.
// - Accept 670 ns SE0 then J as EOP; reject under 330 ns or no J.
// - Bit time is 1.5 Mb/s, four 6 MHz samples.
module usb_ls_bus_state_control #(
   parameter int IDLE_SUSPEND_SAMPLES = usb_ls_pkg::IDLE_SUSPEND_SAMPLES,
   parameter int WAKE_IDLE_SAMPLES = usb_ls_pkg::WAKE_IDLE_SAMPLES
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // Register port
   input wire usb_ls_pkg::reg_req_t REG_REQ_I,
   output logic [usb_ls_pkg::DATA_W-1:0] REG_RDATA_O,
   // USB data lines
   input wire logic DP_I,
   input wire logic DM_I,
   output logic DP_O,
   output logic DM_O,
   output logic DP_OE_O,
   output logic DM_OE_O,
   // Packet engine side
   input wire logic TX_EOP_REQ_I,
   output logic TX_EOP_DONE_O,
   output logic RX_EOP_O,
   // Device state
   output logic DEVICE_RESET_O,
   output logic SUSPENDED_O
);
   import usb_ls_pkg::*;

   typedef struct packed {
      tx_state_t tx_state;
      logic [CNT_W-1:0] tx_cnt;
      logic [CNT_W-1:0] se0_cnt;
      logic [IDLE_W-1:0] idle_cnt;
      logic bus_rst;
      logic suspended;
      logic suspend_request_bit;
      logic force_wakeup_bit;
      logic wake_drive;
      logic packet_end_seen_flag;
      logic bus_reset_flag;
      logic resume_seen_flag;
      logic [DEV_ADDR_W-1:0] dev_addr;
      logic [DATA_W-1:0] rdata;
      logic dp;
      logic dm;
      logic oe;
      logic eop_pulse;
      logic done_pulse;
   } ctl_state_t;

   ctl_state_t q, d;
   sample_t smp;
   logic activity;

   generate
      if (IDLE_SUSPEND_SAMPLES < 1 || IDLE_SUSPEND_SAMPLES >= (1 << IDLE_W) ||
          WAKE_IDLE_SAMPLES < 1 || WAKE_IDLE_SAMPLES >= (1 << IDLE_W)) begin : g_bad_idle
         $error("Idle sample counts must fit the idle counter");
      end
   endgenerate

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
   endfunction

   function automatic logic [IDLE_W-1:0] idle_inc(input logic [IDLE_W-1:0] v);
      idle_inc = (v == {IDLE_W{1'b1}}) ? v : v + 1'b1;
   endfunction

   // -------------------------------------------------------------------
   // Line sampler
   // -------------------------------------------------------------------
   usb_line_sampler #(
      .CLK_HZ(CLK_HZ),
      .SAMPLE_HZ(SAMPLE_HZ)
   ) u_sampler (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESET_N_I),
      .dp_i(DP_I),
      .dm_i(DM_I),
      .smp_o(smp)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      d = q;
      d.eop_pulse = 1'b0;
      d.done_pulse = 1'b0;
      d.rdata = '0;
      activity = 1'b0;

      // Register reads: data stand for the one following cycle only
      if (REG_REQ_I.rd) begin
         case (REG_REQ_I.addr)
            OFS_USB_INTERRUPT_REG_ZERO: begin
               d.rdata[BIT_PACKET_END_SEEN] = q.packet_end_seen_flag;
               d.rdata[BIT_BUS_RESET] = q.bus_reset_flag;
               d.rdata[BIT_RESUME_SEEN] = q.resume_seen_flag;
               d.rdata[BIT_SUSPEND_REQUEST] = q.suspend_request_bit;
            end
            OFS_USB_CONTROL_REG_ONE: begin
               d.rdata[BIT_FORCE_WAKEUP] = q.force_wakeup_bit;
            end
            OFS_BUS_STATUS: begin
               d.rdata[BIT_SUSPENDED] = q.suspended;
               d.rdata[BIT_IDLE_3MS] = (q.idle_cnt >= IDLE_W'(IDLE_SUSPEND_SAMPLES));
               d.rdata[BIT_WAKE_DRIVING] = q.wake_drive;
               d.rdata[BIT_LINE_J] = (smp.line == LINE_J);
               d.rdata[BIT_LINE_SE0] = (smp.line == LINE_SE0);
               d.rdata[BIT_RESET_ACTIVE] = q.bus_rst;
            end
            OFS_DEVICE_ADDRESS: begin
               d.rdata[DEV_ADDR_W-1:0] = q.dev_addr;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end

      // Register writes; flags clear by writing one, a same-cycle event wins
      if (REG_REQ_I.wr) begin
         case (REG_REQ_I.addr)
            OFS_USB_INTERRUPT_REG_ZERO: begin
               if (REG_REQ_I.wdata[BIT_PACKET_END_SEEN]) begin
                  d.packet_end_seen_flag = 1'b0;
               end
               if (REG_REQ_I.wdata[BIT_BUS_RESET]) begin
                  d.bus_reset_flag = 1'b0;
               end
               if (REG_REQ_I.wdata[BIT_RESUME_SEEN]) begin
                  d.resume_seen_flag = 1'b0;
               end
               d.suspend_request_bit = REG_REQ_I.wdata[BIT_SUSPEND_REQUEST];
            end
            OFS_USB_CONTROL_REG_ONE: begin
               d.force_wakeup_bit = REG_REQ_I.wdata[BIT_FORCE_WAKEUP];
            end
            OFS_DEVICE_ADDRESS: begin
               d.dev_addr = REG_REQ_I.wdata[DEV_ADDR_W-1:0];
            end
            default: begin
               d.dev_addr = q.dev_addr;
            end
         endcase
      end

      // Suspend entry follows the request bit directly
      if (d.suspend_request_bit && !q.suspended) begin
         d.suspended = 1'b1;
      end

      // Receive side, once per line sample
      if (smp.tick) begin
         activity = (smp.line != LINE_J);
         if (smp.line == LINE_SE0) begin
            d.se0_cnt = sat_inc(q.se0_cnt);
            // Four bit times: above 2.5 us, below 5.5 us
            if (d.se0_cnt >= RESET_SAMPLES) begin
               d.bus_rst = 1'b1;
            end
         end else begin
            // Own drive is ignored so our EOP is not reported back
            if (smp.line == LINE_J && !q.bus_rst && !q.oe &&
                q.se0_cnt >= EOP_MIN_SAMPLES && q.se0_cnt < RESET_SAMPLES) begin
               d.eop_pulse = 1'b1;
               d.packet_end_seen_flag = 1'b1;
            end
            d.se0_cnt = '0;
            if (q.bus_rst) begin
               d.bus_rst = 1'b0;
               d.bus_reset_flag = 1'b1;
            end
         end
         d.idle_cnt = activity ? '0 : idle_inc(q.idle_cnt);
      end

      // Remote wake-up: gated on idle time, held while the bit stays set
      if (q.force_wakeup_bit && (q.wake_drive ||
          q.idle_cnt >= IDLE_W'(WAKE_IDLE_SAMPLES))) begin
         d.wake_drive = 1'b1;
      end else if (!q.force_wakeup_bit) begin
         d.wake_drive = 1'b0;
      end

      // Suspend exit; host resume K shows up here as activity
      if (q.suspended && (activity || d.bus_rst || d.wake_drive)) begin
         d.suspended = 1'b0;
         d.suspend_request_bit = 1'b0;
         d.resume_seen_flag = 1'b1;
      end

      // EOP transmitter, aligned to sample ticks so widths are exact
      case (q.tx_state)
         TX_IDLE: begin
            if (TX_EOP_REQ_I) begin
               d.tx_state = TX_WAIT;
            end
         end
         TX_WAIT: begin
            if (smp.tick) begin
               d.tx_state = TX_SE0;
               d.tx_cnt = '0;
            end
         end
         TX_SE0: begin
            if (smp.tick) begin
               d.tx_cnt = q.tx_cnt + 1'b1;
               // Eight samples make 1.33 us
               if (q.tx_cnt == EOP_SE0_SAMPLES - 1'b1) begin
                  d.tx_state = TX_J;
                  d.tx_cnt = '0;
               end
            end
         end
         TX_J: begin
            if (smp.tick) begin
               d.tx_cnt = q.tx_cnt + 1'b1;
               if (q.tx_cnt == EOP_J_SAMPLES - 1'b1) begin
                  d.tx_state = TX_IDLE;
                  d.tx_cnt = '0;
                  d.done_pulse = 1'b1;
               end
            end
         end
         default: begin
            d.tx_state = TX_IDLE;
         end
      endcase

      // Bus reset holds transmitter, suspend, wake-up and address cleared; the flags keep their values
      if (d.bus_rst) begin
         d.tx_state = TX_IDLE;
         d.tx_cnt = '0;
         d.suspended = 1'b0;
         d.suspend_request_bit = 1'b0;
         d.force_wakeup_bit = 1'b0;
         d.wake_drive = 1'b0;
         d.dev_addr = '0;
         d.done_pulse = 1'b0;
      end

      // Pin drive; EOP takes the lines before wake-up K
      case (d.tx_state)
         TX_SE0: begin
            d.oe = 1'b1;
            d.dp = 1'b0;
            d.dm = 1'b0;
         end
         TX_J: begin
            d.oe = 1'b1;
            d.dp = 1'b0;
            d.dm = 1'b1;
         end
         default: begin
            d.oe = d.wake_drive;
            d.dp = d.wake_drive;
            d.dm = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs, all straight from flops
   // -------------------------------------------------------------------
   assign REG_RDATA_O = q.rdata;
   assign DP_O = q.dp;
   assign DM_O = q.dm;
   assign DP_OE_O = q.oe;
   assign DM_OE_O = q.oe;
   assign TX_EOP_DONE_O = q.done_pulse;
   assign RX_EOP_O = q.eop_pulse;
   assign DEVICE_RESET_O = q.bus_rst;
   assign SUSPENDED_O = q.suspended;

endmodule

`default_nettype wire

// ==== testbench/usb_ls_bus_state_control_properties.sv ====
// Concurrent checks on the ports of the low-speed USB bus-state block
`timescale 1ns/1ps
`default_nettype none
module usb_ls_bus_state_checker #(
   parameter int IDLE_SUSPEND_SAMPLES = 20,
   parameter int WAKE_IDLE_SAMPLES = 40
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // Data lines
   input wire logic DP_I,
   input wire logic DM_I,
   input wire logic DP_O,
   input wire logic DM_O,
   input wire logic DP_OE_O,
   // Packet engine side and device state
   input wire logic TX_EOP_DONE_O,
   input wire logic RX_EOP_O,
   input wire logic DEVICE_RESET_O,
   input wire logic SUSPENDED_O
);
   // ----------------------------------------------------------------
   // Helper counters, in clocks; a sample is 16 or 17 clocks
   // ----------------------------------------------------------------
   logic tx_se0, tx_j, k_drv, in_se0, in_j, in_k;
   int c_tse0, c_tj, c_ise0, c_ij, w_se0;
   assign tx_se0 = DP_OE_O & ~DP_O & ~DM_O;
   assign tx_j = DP_OE_O & ~DP_O & DM_O;
   assign k_drv = DP_OE_O & DP_O & ~DM_O;
   assign in_se0 = ~DP_I & ~DM_I;
   assign in_j = ~DP_I & DM_I;
   assign in_k = DP_I & ~DM_I;
   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         c_tse0 <= 0;
         c_tj <= 0;
         c_ise0 <= 0;
         c_ij <= 0;
         w_se0 <= 0;
      end else begin
         c_tse0 <= tx_se0 ? c_tse0 + 1 : 0;
         c_tj <= tx_j ? c_tj + 1 : 0;
         c_ise0 <= in_se0 ? c_ise0 + 1 : 0;
         c_ij <= in_j ? c_ij + 1 : 0;
         if (!in_se0 && c_ise0 != 0) begin
            w_se0 <= c_ise0;
         end
      end
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_eop_se0;
      $fell(tx_se0) && tx_j |-> c_tse0 >= 125 && c_tse0 <= 150;
   endproperty
   a_eop_se0: assert property (p_eop_se0) else $error("EOP SE0 width wrong");
   property p_eop_j;
      $fell(DP_OE_O) && $past(tx_j) |-> c_tj >= 60 && c_tj <= 72;
   endproperty
   a_eop_j: assert property (p_eop_j) else $error("EOP idle bit wrong");
   property p_done;
      TX_EOP_DONE_O |-> !DP_OE_O && $past(tx_j);
   endproperty
   a_done: assert property (p_done) else $error("EOP done without release");
   property p_rx_j;
      RX_EOP_O |-> $past(in_j) && w_se0 >= 33 && !DEVICE_RESET_O;
   endproperty
   a_rx_j: assert property (p_rx_j) else $error("EOP seen without SE0 then J");
   property p_reset_by;
      c_ise0 == 556 |-> DEVICE_RESET_O;
   endproperty
   a_reset_by: assert property (p_reset_by) else $error("Bus reset missed");
   property p_reset_min;
      $rose(DEVICE_RESET_O) |-> c_ise0 >= 240;
   endproperty
   a_reset_min: assert property (p_reset_min) else $error("Bus reset too early");
   property p_reset_end;
      DEVICE_RESET_O && in_j |-> ##[1:40] !DEVICE_RESET_O;
   endproperty
   a_reset_end: assert property (p_reset_end) else $error("Bus reset stuck");
   property p_susp_k;
      SUSPENDED_O && in_k && !DP_OE_O |-> ##[1:40] !SUSPENDED_O;
   endproperty
   a_susp_k: assert property (p_susp_k) else $error("Suspend kept on activity");
   property p_wake_idle;
      $rose(k_drv) |-> c_ij >= (WAKE_IDLE_SAMPLES - 1) * 16;
   endproperty
   a_wake_idle: assert property (p_wake_idle) else $error("Wake K too early");
   property p_wake_susp;
      $rose(k_drv) |-> ##[0:2] !SUSPENDED_O;
   endproperty
   a_wake_susp: assert property (p_wake_susp) else $error("Wake kept suspend");
   c_rx: cover property (RX_EOP_O);
   c_rst: cover property ($fell(DEVICE_RESET_O));
   c_wake: cover property ($rose(k_drv));
endmodule

bind usb_ls_bus_state_control usb_ls_bus_state_checker #(
   .IDLE_SUSPEND_SAMPLES(IDLE_SUSPEND_SAMPLES),
   .WAKE_IDLE_SAMPLES(WAKE_IDLE_SAMPLES)
) checker_i (
   .REF_CLK_I(REF_CLK_I),
   .RESET_N_I(RESET_N_I),
   .DP_I(DP_I),
   .DM_I(DM_I),
   .DP_O(DP_O),
   .DM_O(DM_O),
   .DP_OE_O(DP_OE_O),
   .TX_EOP_DONE_O(TX_EOP_DONE_O),
   .RX_EOP_O(RX_EOP_O),
   .DEVICE_RESET_O(DEVICE_RESET_O),
   .SUSPENDED_O(SUSPENDED_O)
);
`default_nettype wire

// ==== testbench/usb_host_model.sv ====
// Upstream host port model sharing the data lines with the device
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
   import usb_ls_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Device drivers
   input wire logic dp_i,
   input wire logic dm_i,
   input wire logic oe_i,
   // Resolved lines
   output logic dp_o,
   output logic dm_o
);
   localparam int BIT_CLK = 67;
   logic host_oe = 1'b0;
   line_t host_ln = LINE_J;
   // Released bus idles at J through the pull-up on dm
   always_comb begin
      if (oe_i) begin
         {dp_o, dm_o} = {dp_i, dm_i};
      end else if (host_oe) begin
         {dp_o, dm_o} = host_ln;
      end else begin
         {dp_o, dm_o} = LINE_J;
      end
   end
   task automatic drive(input line_t ln, input int n);
      @(posedge clk_i);
      host_oe <= 1'b1;
      host_ln <= ln;
      repeat (n - 1) @(posedge clk_i);
   endtask
   task automatic release_bus();
      @(posedge clk_i);
      host_oe <= 1'b0;
   endtask
   // Keep-alive and resume both close this way
   task automatic send_eop(input int se0_clk);
      drive(LINE_SE0, se0_clk);
      drive(LINE_J, BIT_CLK);
      release_bus();
   endtask
endmodule
`default_nettype wire

// ==== testbench/usb_ls_bus_state_control_test.sv ====
// Self-checking bench for the low-speed USB bus-state block
`timescale 1ns/1ps
`default_nettype none
module usb_ls_bus_state_control_test;
   import usb_ls_pkg::*;
   // ----------------------------------------------------------------
   // Signals and model state
   // ----------------------------------------------------------------
   localparam int BIT = 67;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   reg_req_t req = '0;
   logic tx_req = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic dp, dm, dp_o, dm_o, oe, dm_oe, done, rx_eop, dev_rst, susp;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int rx_n = 0;
   int seed = 32'hff32;
   int i, n0, n1, v;
   // SE0 width in clocks, and whether an EOP is due
   int wid_q[$] = {134, 67, 30, 134};
   int acc_q[$] = {1, 1, 0, 0};
   always #5 clk = ~clk;
   usb_ls_bus_state_control #(.IDLE_SUSPEND_SAMPLES(20), .WAKE_IDLE_SAMPLES(40)) dut (
      .REF_CLK_I(clk), .RESET_N_I(rst_n), .REG_REQ_I(req), .REG_RDATA_O(rdata),
      .DP_I(dp), .DM_I(dm), .DP_O(dp_o), .DM_O(dm_o), .DP_OE_O(oe), .DM_OE_O(dm_oe),
      .TX_EOP_REQ_I(tx_req), .TX_EOP_DONE_O(done), .RX_EOP_O(rx_eop),
      .DEVICE_RESET_O(dev_rst), .SUSPENDED_O(susp));
   usb_host_model host (.clk_i(clk), .dp_i(dp_o), .dm_i(dm_o), .oe_i(oe), .dp_o(dp), .dm_o(dm));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rx_eop === 1'b1) rx_n <= rx_n + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input int e, input string nm);
      @(posedge clk);
      req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 check(nm, 16'(rdata), 16'(e));
   endtask
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 check("oe_rst", oe, 0);
      rd(OFS_USB_INTERRUPT_REG_ZERO, 0, "ir0_rst");
      rd(OFS_DEVICE_ADDRESS, 0, "addr_rst");
      wr(4'h9, 8'hff);
      rd(4'h9, 0, "unmapped");
      foreach (wid_q[k]) begin
         n0 = rx_n;
         host.drive(LINE_SE0, wid_q[k]);
         host.drive(k == 3 ? LINE_K : LINE_J, BIT);
         host.release_bus();
         repeat (40) @(posedge clk);
         check("rx_eop", 16'(rx_n - n0), 16'(acc_q[k]));
         check("no_reset", dev_rst, 0);
      end
      rd(OFS_USB_INTERRUPT_REG_ZERO, 1, "eop_flag");
      wr(OFS_USB_INTERRUPT_REG_ZERO, 8'h07);
      // Transmit: count driven SE0 and J cycles up to the done pulse
      n0 = 0;
      n1 = 0;
      @(posedge clk);
      tx_req <= 1'b1;
      @(posedge clk);
      tx_req <= 1'b0;
      for (i = 0; i < 400 && done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
         if (oe === 1'b1 && {dp_o, dm_o} === LINE_SE0) n0++;
         if (oe === 1'b1 && {dp_o, dm_o} === LINE_J) n1++;
      end
      check("tx_se0", n0 >= 125 && n0 <= 150, 1);
      check("tx_j", n1 >= 60 && n1 <= 72, 1);
      check("tx_done", done, 1);
      check("tx_rel", {oe, dm_oe}, 0);
      // Suspend, then host resume
      wr(OFS_USB_INTERRUPT_REG_ZERO, 8'h08);
      @(posedge clk);
      #1 check("susp", susp, 1);
      host.drive(LINE_K, 200);
      host.send_eop(134);
      repeat (40) @(posedge clk);
      check("resume", susp, 0);
      rd(OFS_USB_INTERRUPT_REG_ZERO, 8'h05, "ir0_res");
      // Bus reset while suspended, with a random address set first
      wr(OFS_USB_INTERRUPT_REG_ZERO, 8'h07);
      v = $random(seed);
      wr(OFS_DEVICE_ADDRESS, 8'(v));
      rd(OFS_DEVICE_ADDRESS, v & 8'h7f, "addr");
      wr(OFS_USB_INTERRUPT_REG_ZERO, 8'h08);
      host.drive(LINE_SE0, 550);
      #1 check("reset_5u5", dev_rst, 1);
      check("reset_wake", susp, 0);
      host.drive(LINE_SE0, 300);
      #1 check("reset_hold", dev_rst, 1);
      host.release_bus();
      for (i = 0; i < 60 && dev_rst !== 1'b0; i++) @(posedge clk);
      #1 check("reset_end", dev_rst, 0);
      rd(OFS_USB_INTERRUPT_REG_ZERO, 8'h06, "ir0_rst");
      rd(OFS_DEVICE_ADDRESS, 0, "addr_clr");
      v = $random(seed);
      wr(OFS_DEVICE_ADDRESS, 8'(v));
      rd(OFS_DEVICE_ADDRESS, v & 8'h7f, "addr_new");
      // Remote wake asked for too soon; K must wait for idle
      wr(OFS_USB_INTERRUPT_REG_ZERO, 8'h0f);
      wr(OFS_USB_CONTROL_REG_ONE, 8'h01);
      n0 = 0;
      repeat (400) begin
         @(posedge clk);
         #1;
         if (oe !== 1'b0) n0++;
      end
      check("wake_wait", n0, 0);
      for (i = 0; i < 1000 && oe !== 1'b1; i++) @(posedge clk);
      repeat (300) @(posedge clk);
      #1 check("wake_k", {oe, dm_oe, dp_o, dm_o}, 4'b1110);
      check("wake_susp", susp, 0);
      rd(OFS_USB_CONTROL_REG_ONE, 1, "cr1");
      rd(OFS_BUS_STATUS, 8'h04, "status_wake");
      wr(OFS_USB_CONTROL_REG_ONE, 8'h00);
      repeat (2) @(posedge clk);
      #1 check("wake_rel", oe, 0);
      rd(OFS_USB_INTERRUPT_REG_ZERO, 8'h04, "ir0_wake");
      end_sim();
   end
endmodule
`default_nettype wire
